/* File: hw/alo_pkg.sv */
// Types shared by the alarm/output router
package alo_pkg;
   typedef enum logic [4:0] {
      ALO_SRC_NONE = 5'h00, ALO_SRC_HEAT = 5'h01, ALO_SRC_COOL = 5'h02,
      ALO_SRC_ALARM1 = 5'h03, ALO_SRC_ALARM2 = 5'h04, ALO_SRC_ALARM3 = 5'h05,
      ALO_SRC_ALARM4 = 5'h06, ALO_SRC_HEATER = 5'h07, ALO_SRC_BURNOUT = 5'h08,
      ALO_SRC_SHORT = 5'h09, ALO_SRC_INERR = 5'h0A, ALO_SRC_PEND = 5'h0B,
      ALO_SRC_STAGE = 5'h0C, ALO_SRC_RUN = 5'h0D, ALO_SRC_TSIG1 = 5'h0E,
      ALO_SRC_TSIG2 = 5'h0F, ALO_SRC_COMB = 5'h10, ALO_SRC_WORK1 = 5'h11,
      ALO_SRC_WORK8 = 5'h18
   } alo_src_t;

   // Internal alarm, control and status signals
   typedef struct packed {
      logic heat_on;
      logic cool_on;
      logic [3:0] alarm;
      logic heater_burnout_alarm;
      logic input_error;
      logic program_end;
      logic stage;
      logic run;
      logic [1:0] time_signal;
      logic [7:0] work_bit;
   } alo_sig_t;

   // Fitted hardware options
   typedef struct packed {
      logic standard_model;
      logic has_ctl2;
      logic compact_variant;
      logic heater_detect;
      logic [1:0] ctl_linear;
   } alo_strap_t;

   // Release requests, one-cycle pulses
   typedef struct packed {
      logic function_key;
      logic [5:0] event_in;
   } alo_release_t;
endpackage

/* File: hw/alo_regs.svh */
// Register map, reset values and timing counts of the alarm/output router
`ifndef ALO_REGS_SVH
`define ALO_REGS_SVH
// ----------------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------------
// Functional notes
// - With latch on, heater short alarm stays set until a release occurs.
// - Writing the short current setting to 50.0 A releases the latch.
// - Reset, function key or assigned event inputs 1-6 release the latch.
// - Entering a configuration level forces the latched short output off.
// - Short alarm hysteresis 0.1-50.0 A, default 0.1, only with latch off.
// - Loop burnout interval 0-9999 s, default 0; zero disables it.
// - Loop burnout only with alarm 1 type 12 on the standard model.
// - Evaluation starts when |SP-PV| exceeds level; default 8.0 or 10.00.
// - Burnout if deviation not reduced by band within interval; 3.0/0.20.
// - Control outputs 1 and 2 each route one of the listed sources.
// - Cooling routed under standard control drives 0% output.
// - Alarm, status, time signal and work bits only on relay/voltage.
// - Output 1 defaults heating, output 2 none; heat/cool forces cooling.
// - Work bits selectable only with the logic operation function on.
// - Aux outputs 1-4 take the same list; defaults alarms 1 to 4.
// - Heat/cool without output 2 routes cooling to aux 2 or aux 4.
// - With heater current detection, aux 1 defaults to heater burnout.
// - Combined alarm ORs sources whose weights appear in its code.
// - Combined alarm code 0 to 255, reset value 49.
// ----------------------------------------------------------------------
// Offsets (byte addresses for the first four, word addresses for the last four)
// ----------------------------------------------------------------------
`define ALO_OFF_CTRL 4'h0
`define ALO_OFF_SHORT 4'h4
`define ALO_OFF_LOOP_TIME 4'h8
`define ALO_OFF_LOOP_LVL 4'hC
`define ALO_ADR_CTL_SEL 3'h4
`define ALO_ADR_AUX_SEL 3'h5
`define ALO_ADR_COMB 3'h6
`define ALO_ADR_STATUS 3'h7
// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define ALO_RST_SHORT_SET 10'h064
`define ALO_SHORT_TOP 10'h1F4
`define ALO_RST_SHORT_HYST 10'h001
`define ALO_RST_LOOP_TIME 14'h0000
`define ALO_LOOP_TIME_MAX 14'h270F
`define ALO_RST_LOOP_LVL 16'h0050
`define ALO_RST_LOOP_BAND 16'h001E
`define ALO_LOOP_TYPE 8'h0C
`define ALO_RST_COMB 8'h31
`define ALO_RST_ALARM1_TYPE 8'h02
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ALO_CLK_HZ 200000000
`define ALO_TICK_S 1
`endif

/* File: hw/alo_router.sv */
// Heater short latch, loop burnout detection and output routing with Avalon-MM registers
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "alo_regs.svh"
module alo_router #(
   parameter int unsigned SEC_CYCLES = `ALO_TICK_S * `ALO_CLK_HZ
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire alo_pkg::alo_sig_t sig,
   input wire alo_pkg::alo_strap_t strap,
   input wire alo_pkg::alo_release_t release_req,
   input wire logic [9:0] short_current,
   input wire logic signed [15:0] set_point,
   input wire logic signed [15:0] process_value,
   input wire logic config_level,
   output logic [1:0] ctl_out,
   output logic [3:0] aux_out,
   output logic heater_short_alarm,
   output logic loop_burnout_alarm,
   output logic combined_alarm
);
   import alo_pkg::*;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic latch_en_reg;
   logic hc_mode_reg;
   logic logic_en_reg;
   logic fkey_cancel_reg;
   logic [5:0] event_cancel_reg;
   logic [7:0] alarm1_type_reg;
   logic [9:0] short_set_reg;
   logic [9:0] short_hyst_reg;
   logic [13:0] loop_time_reg;
   logic [15:0] loop_lvl_reg;
   logic [15:0] loop_band_reg;
   alo_src_t ctl_sel_reg [2];
   alo_src_t aux_sel_reg [4];
   logic aux1_written_reg;
   logic [7:0] comb_code_reg;
   logic short_raw_reg;
   logic short_held_reg;
   logic loop_eval_reg;
   logic [15:0] loop_ref_reg;
   logic [13:0] loop_cnt_reg;
   logic [31:0] tick_cnt_reg;
   logic tick_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;

   logic wr_go;
   logic release_now;
   logic loop_enable;
   logic [15:0] dev_abs;
   logic short_on;
   logic [9:0] short_off_lvl;
   logic alarm1_eff;
   logic comb_now;
   alo_src_t ctl_eff [2];
   alo_src_t aux_eff [4];

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [15:0] abs_diff(input logic signed [15:0] a,
                                            input logic signed [15:0] b);
      logic signed [16:0] d;
      d = 17'(a) - 17'(b);
      if (d < 0) begin
         d = -d;
      end
      abs_diff = (d > 17'sh0_FFFF) ? 16'hFFFF : d[15:0];
   endfunction

   // Value of one routed output for its selected source
   function automatic logic route(input alo_src_t s, input logic linear);
      logic v;
      v = 1'b0;
      if (linear && s > ALO_SRC_COOL) begin
         v = 1'b0;
      end else if (s >= ALO_SRC_WORK1 && !logic_en_reg) begin
         v = 1'b0;
      end else begin
         unique case (s) inside
            ALO_SRC_NONE: v = 1'b0;
            ALO_SRC_HEAT: v = sig.heat_on;
            ALO_SRC_COOL: v = hc_mode_reg & sig.cool_on;
            ALO_SRC_ALARM1: v = alarm1_eff;
            ALO_SRC_ALARM2: v = sig.alarm[1];
            ALO_SRC_ALARM3: v = sig.alarm[2];
            ALO_SRC_ALARM4: v = sig.alarm[3];
            ALO_SRC_HEATER: v = sig.heater_burnout_alarm | short_on;
            ALO_SRC_BURNOUT: v = sig.heater_burnout_alarm;
            ALO_SRC_SHORT: v = short_on;
            ALO_SRC_INERR: v = sig.input_error;
            ALO_SRC_PEND: v = sig.program_end;
            ALO_SRC_STAGE: v = sig.stage;
            ALO_SRC_RUN: v = sig.run;
            ALO_SRC_TSIG1: v = sig.time_signal[0];
            ALO_SRC_TSIG2: v = sig.time_signal[1];
            ALO_SRC_COMB: v = comb_now;
            [ALO_SRC_WORK1:ALO_SRC_WORK8]: v = sig.work_bit[3'(s - ALO_SRC_WORK1)];
            default: v = 1'b0;
         endcase
      end
      route = v;
   endfunction

   // ----------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------
   assign wr_go = avs_write && !wait_reg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wait_reg <= 1'b1;
      end else if ((avs_read || avs_write) && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read && wait_reg) begin
         unique case (avs_address)
            3'h0: rdata_reg <= {8'h00, alarm1_type_reg, 6'h00, event_cancel_reg,
                                fkey_cancel_reg, logic_en_reg, hc_mode_reg, latch_en_reg};
            3'h1: rdata_reg <= {6'h00, short_hyst_reg, 6'h00, short_set_reg};
            3'h2: rdata_reg <= {18'h0_0000, loop_time_reg};
            3'h3: rdata_reg <= {loop_band_reg, loop_lvl_reg};
            `ALO_ADR_CTL_SEL: rdata_reg <= {19'h0_0000, ctl_sel_reg[1], 3'h0, ctl_sel_reg[0]};
            `ALO_ADR_AUX_SEL: rdata_reg <= {3'h0, aux_sel_reg[3], 3'h0, aux_sel_reg[2],
                                            3'h0, aux_sel_reg[1], 3'h0, aux_sel_reg[0]};
            `ALO_ADR_COMB: rdata_reg <= {24'h00_0000, comb_code_reg};
            `ALO_ADR_STATUS: rdata_reg <= {21'h0_0000, combined_alarm, aux_out, ctl_out,
                                           short_raw_reg, loop_eval_reg,
                                           loop_burnout_alarm, short_held_reg};
         endcase
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         latch_en_reg <= 1'b0;
         hc_mode_reg <= 1'b0;
         logic_en_reg <= 1'b0;
         fkey_cancel_reg <= 1'b0;
         event_cancel_reg <= 6'h00;
         alarm1_type_reg <= `ALO_RST_ALARM1_TYPE;
      end else if (wr_go && avs_address == `ALO_OFF_CTRL >> 2) begin
         latch_en_reg <= avs_writedata[0];
         hc_mode_reg <= avs_writedata[1];
         logic_en_reg <= avs_writedata[2];
         fkey_cancel_reg <= avs_writedata[3];
         event_cancel_reg <= avs_writedata[9:4];
         alarm1_type_reg <= avs_writedata[23:16];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         short_set_reg <= `ALO_RST_SHORT_SET;
         short_hyst_reg <= `ALO_RST_SHORT_HYST;
      end else if (wr_go && avs_address == `ALO_OFF_SHORT >> 2) begin
         short_set_reg <= (avs_writedata[9:0] > `ALO_SHORT_TOP) ? `ALO_SHORT_TOP
                                                                : avs_writedata[9:0];
         if (avs_writedata[25:16] != 10'h000 && avs_writedata[25:16] <= `ALO_SHORT_TOP) begin
            short_hyst_reg <= avs_writedata[25:16];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         loop_time_reg <= `ALO_RST_LOOP_TIME;
         loop_lvl_reg <= `ALO_RST_LOOP_LVL;
         loop_band_reg <= `ALO_RST_LOOP_BAND;
      end else if (wr_go && avs_address == `ALO_OFF_LOOP_TIME >> 2) begin
         loop_time_reg <= (avs_writedata[13:0] > `ALO_LOOP_TIME_MAX) ? `ALO_LOOP_TIME_MAX
                                                                     : avs_writedata[13:0];
      end else if (wr_go && avs_address == `ALO_OFF_LOOP_LVL >> 2) begin
         loop_lvl_reg <= avs_writedata[15:0];
         loop_band_reg <= avs_writedata[31:16];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctl_sel_reg[0] <= ALO_SRC_HEAT;
         ctl_sel_reg[1] <= ALO_SRC_NONE;
         aux_sel_reg[0] <= ALO_SRC_ALARM1;
         aux_sel_reg[1] <= ALO_SRC_ALARM2;
         aux_sel_reg[2] <= ALO_SRC_ALARM3;
         aux_sel_reg[3] <= ALO_SRC_ALARM4;
         aux1_written_reg <= 1'b0;
      end else if (wr_go && avs_address == `ALO_ADR_CTL_SEL) begin
         ctl_sel_reg[0] <= alo_src_t'(avs_writedata[4:0]);
         ctl_sel_reg[1] <= alo_src_t'(avs_writedata[12:8]);
      end else if (wr_go && avs_address == `ALO_ADR_AUX_SEL) begin
         for (int i = 0; i < 4; i++) begin
            aux_sel_reg[i] <= alo_src_t'(avs_writedata[8*i +: 5]);
         end
         aux1_written_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         comb_code_reg <= `ALO_RST_COMB;
      end else if (wr_go && avs_address == `ALO_ADR_COMB) begin
         comb_code_reg <= avs_writedata[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Heater short alarm with latch
   // ----------------------------------------------------------------------
   assign release_now = (release_req.function_key && fkey_cancel_reg)
                        || |(release_req.event_in & event_cancel_reg)
                        || (wr_go && avs_address == `ALO_OFF_SHORT >> 2
                            && avs_writedata[9:0] == `ALO_SHORT_TOP);
   assign short_off_lvl = (short_set_reg > short_hyst_reg) ? short_set_reg - short_hyst_reg
                                                           : 10'h000;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         short_raw_reg <= 1'b0;
      end else if (short_current >= short_set_reg) begin
         short_raw_reg <= 1'b1;
      end else if (latch_en_reg || short_current < short_off_lvl) begin
         short_raw_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || config_level) begin
         short_held_reg <= 1'b0;
      end else if (!latch_en_reg) begin
         short_held_reg <= 1'b0;
      end else if (short_raw_reg) begin
         short_held_reg <= 1'b1;
      end else if (release_now) begin
         short_held_reg <= 1'b0;
      end
   end

   assign short_on = !config_level && (short_raw_reg || short_held_reg);

   // ----------------------------------------------------------------------
   // Loop burnout detection
   // ----------------------------------------------------------------------
   assign loop_enable = loop_time_reg != 14'h0000 && alarm1_type_reg == `ALO_LOOP_TYPE
                        && strap.standard_model;
   assign dev_abs = abs_diff(set_point, process_value);

   always_ff @(posedge sys_clk) begin
      if (sys_rst || tick_reg) begin
         tick_cnt_reg <= 32'h0000_0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (tick_cnt_reg == SEC_CYCLES - 2);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !loop_enable || dev_abs <= loop_lvl_reg) begin
         loop_eval_reg <= 1'b0;
         loop_ref_reg <= 16'h0000;
         loop_cnt_reg <= 14'h0000;
         loop_burnout_alarm <= 1'b0;
      end else if (!loop_eval_reg) begin
         loop_eval_reg <= 1'b1;
         loop_ref_reg <= dev_abs;
         loop_cnt_reg <= 14'h0000;
      end else if (tick_reg) begin
         if (loop_cnt_reg + 14'h0001 >= loop_time_reg) begin
            loop_cnt_reg <= 14'h0000;
            loop_ref_reg <= dev_abs;
            loop_burnout_alarm <= !(loop_ref_reg > dev_abs
                                    && loop_ref_reg - dev_abs > loop_band_reg);
         end else begin
            loop_cnt_reg <= loop_cnt_reg + 14'h0001;
         end
      end
   end

   assign alarm1_eff = loop_enable ? loop_burnout_alarm : sig.alarm[0];

   // ----------------------------------------------------------------------
   // Combined alarm and routing
   // ----------------------------------------------------------------------
   assign comb_now = |(comb_code_reg[6:0] & {sig.input_error, short_on,
                       sig.heater_burnout_alarm, sig.alarm[3:1], alarm1_eff});

   always_comb begin
      ctl_eff[0] = ctl_sel_reg[0];
      ctl_eff[1] = hc_mode_reg ? ALO_SRC_COOL : ctl_sel_reg[1];
      if (!strap.has_ctl2) begin
         ctl_eff[1] = ALO_SRC_NONE;
      end
      for (int i = 0; i < 4; i++) begin
         aux_eff[i] = aux_sel_reg[i];
      end
      if (strap.heater_detect && !aux1_written_reg) begin
         aux_eff[0] = ALO_SRC_BURNOUT;
      end
      if (hc_mode_reg && !strap.has_ctl2) begin
         if (strap.compact_variant) begin
            aux_eff[1] = ALO_SRC_COOL;
         end else begin
            aux_eff[3] = ALO_SRC_COOL;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctl_out <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ctl_out[i] <= strap.standard_model
                          && route(ctl_eff[i], strap.ctl_linear[i]);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         aux_out <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            aux_out[i] <= route(aux_eff[i], 1'b0);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         heater_short_alarm <= 1'b0;
         combined_alarm <= 1'b0;
      end else begin
         heater_short_alarm <= short_on;
         combined_alarm <= comb_now;
      end
   end
endmodule
`default_nettype wire

/* File: verif/alo_chk.sv */
// Port-level assertions for the alarm/output router
`timescale 1ns/1ps
`default_nettype none
module alo_chk
   import alo_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire alo_pkg::alo_sig_t sig,
   input wire alo_pkg::alo_strap_t strap,
   input wire logic config_level,
   input wire logic [1:0] ctl_out,
   input wire logic [3:0] aux_out,
   input wire logic heater_short_alarm,
   input wire logic loop_burnout_alarm,
   input wire logic combined_alarm
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ----
   // Bus handshake
   // ----
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_one_wait: assert property (s_req |=> s_ans)
      else $error("waitrequest not a single wait");
   a_rd_data_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   a_reset_quiet: assert property ($fell(sys_rst) |-> avs_waitrequest && !heater_short_alarm
      && !loop_burnout_alarm && !combined_alarm && ctl_out == 2'h0 && aux_out == 4'h0)
      else $error("outputs not quiet after reset");
   // ----
   // Alarms and routing
   // ----
   a_config_off: assert property (config_level |=> !heater_short_alarm)
      else $error("short alarm on in configuration level");
   a_linear_zero: assert property (strap.ctl_linear[0] && !sig.heat_on && !sig.cool_on
      |=> !ctl_out[0])
      else $error("linear output driven by a status source");
   a_ctl2_absent: assert property (!strap.has_ctl2 |=> !ctl_out[1])
      else $error("missing output 2 driven");
   a_loop_model: assert property ($rose(loop_burnout_alarm) |-> $past(strap.standard_model))
      else $error("loop burnout on non standard model");
   sequence s_calm;
      sig.alarm == 4'h0 && !sig.heater_burnout_alarm && !sig.input_error
         && !heater_short_alarm && !loop_burnout_alarm && !config_level;
   endsequence
   a_comb_quiet: assert property (s_calm [*2] |-> !combined_alarm)
      else $error("combined alarm with no source");
endmodule
bind alo_router alo_chk #(.SEC_CYCLES(SEC_CYCLES)) u_alo_chk (.sys_clk, .sys_rst, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .sig, .strap, .config_level, .ctl_out,
   .aux_out, .heater_short_alarm, .loop_burnout_alarm, .combined_alarm);
`default_nettype wire

/* File: verif/alo_drv_model.sv */
// Output driver model: relay/voltage drives, linear outputs left off
`timescale 1ns/1ps
`default_nettype none
module alo_drv_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [1:0] ctl_out,
   input wire logic [3:0] aux_out,
   input wire logic [1:0] ctl_linear,
   output logic [5:0] relay_on
);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         relay_on <= 6'h00;
      end else begin
         relay_on <= {aux_out, ctl_out & ~ctl_linear};
      end
   end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the alarm/output router
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import alo_pkg::*;
   localparam int unsigned SEC = 20;
   localparam alo_sig_t PA = {1'b1, 1'b1, 4'h5, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 8'h55};
   localparam logic [31:0] RV [7] = '{32'h0002_0000, 32'h0001_0064, 32'h0000_0000,
      32'h001E_0050, 32'h0000_0001, 32'h0605_0403, 32'h0000_0031};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] avs_address = 3'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   alo_sig_t sig = '0;
   alo_strap_t strap = 6'h34;
   alo_release_t release_req = '0;
   logic [9:0] short_current = 10'h000;
   logic signed [15:0] set_point = 16'h0000;
   logic signed [15:0] process_value = 16'h0000;
   logic config_level = 1'b0;
   logic [1:0] ctl_out;
   logic [3:0] aux_out;
   logic heater_short_alarm;
   logic loop_burnout_alarm;
   logic combined_alarm;
   logic [5:0] relay_on;
   logic [31:0] rd;
   alo_sig_t s;
   int failures = 0;
   int num_checks = 0;
   int i;
   int k;
   always #2.5 sys_clk = ~sys_clk;
   alo_router #(.SEC_CYCLES(SEC)) u_alo_router (.sys_clk, .sys_rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sig, .strap, .release_req,
      .short_current, .set_point, .process_value, .config_level, .ctl_out, .aux_out,
      .heater_short_alarm, .loop_burnout_alarm, .combined_alarm);
   alo_drv_model u_alo_drv_model (.sys_clk, .sys_rst, .ctl_out, .aux_out,
      .ctl_linear(strap.ctl_linear), .relay_on);
   // ----
   // Tasks
   // ----
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      int n;
      logic w;
      n = 0;
      w = 1'b1;
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      while (w !== 1'b0) begin
         @(posedge sys_clk);
         w = avs_waitrequest;
         rd = avs_readdata;
         n++;
         if (n > 50) begin
            failures++;
            $display("BAD t=%0t bus timeout", $time);
            close_out();
         end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n + 1) @(posedge sys_clk);
   endtask
   task automatic put(input alo_sig_t v);
      @(posedge sys_clk);
      sig <= v;
      wt(3);
   endtask
   task automatic pulse(input logic [6:0] p);
      @(posedge sys_clk);
      release_req <= p;
      @(posedge sys_clk);
      release_req <= '0;
      wt(2);
   endtask
   task automatic arm();
      @(posedge sys_clk);
      short_current <= 10'h258;
      wt(2);
      short_current <= 10'h000;
      wt(2);
   endtask
   task automatic loop_try(input logic [31:0] ctrl, input logic [31:0] tm, input logic exp);
      bus(1'b1, 3'h2, tm);
      bus(1'b1, 3'h0, ctrl);
      process_value <= 16'h00C8;
      wt(30);
      chk(32'(loop_burnout_alarm), 32'h0000_0000);
      wt(150);
      chk(32'(loop_burnout_alarm), 32'(exp));
      process_value <= 16'h0000;
      wt(10);
      chk(32'(loop_burnout_alarm), 32'h0000_0000);
   endtask
   function automatic logic route(input int c, input alo_sig_t v, input logic wen);
      logic [24:0] t;
      t = {v.work_bit & {8{wen}}, v.alarm[0] | v.heater_burnout_alarm, v.time_signal, v.run,
         v.stage, v.program_end, v.input_error, 1'b0, v.heater_burnout_alarm,
         v.heater_burnout_alarm, v.alarm, 1'b0, v.heat_on, 1'b0};
      return t[c];
   endfunction
   initial begin
      repeat (100000) @(posedge sys_clk);
      failures++;
      $display("BAD t=%0t run timeout", $time);
      close_out();
   end
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 7; i++) begin
         bus(1'b0, i[2:0], 32'h0000_0000);
         chk(rd, RV[i]);
      end
      for (k = 0; k < 2; k++) begin
         s = k[0] ? ~PA : PA;
         put(s);
         chk(32'(ctl_out), 32'({1'b0, s.heat_on}));
         chk(32'(aux_out), 32'({s.alarm[3:1], s.heater_burnout_alarm}));
         chk(32'(relay_on), 32'({s.alarm[3:1], s.heater_burnout_alarm, 1'b0, s.heat_on}));
      end
      for (k = 0; k < 4; k++) begin
         bus(1'b1, 3'h0, 32'(k[1]) << 2);
         s = k[0] ? ~PA : PA;
         for (i = 0; i < 25; i++) begin
            bus(1'b1, 3'h4, 32'(i));
            put(s);
            chk(32'(ctl_out[0]), 32'(route(i, s, k[1])));
         end
      end
      bus(1'b1, 3'h0, 32'h0000_0002);
      bus(1'b1, 3'h4, 32'h0000_0001);
      for (k = 0; k < 4; k++) begin
         s = k[0] ? ~PA : PA;
         strap.has_ctl2 <= ~k[1];
         strap.compact_variant <= k[0];
         put(s);
         chk(32'(ctl_out[1]), k[1] ? 32'h0000_0000 : 32'(s.cool_on));
         chk(32'(aux_out[3]), k == 2 ? 32'(s.cool_on) : 32'(s.alarm[3]));
         chk(32'(aux_out[1]), k == 3 ? 32'(s.cool_on) : 32'(s.alarm[1]));
      end
      strap.has_ctl2 <= 1'b1;
      bus(1'b1, 3'h0, 32'h0000_0000);
      bus(1'b1, 3'h4, 32'h0000_0003);
      strap.ctl_linear <= 2'h1;
      s = PA;
      s.heat_on = 1'b0;
      s.cool_on = 1'b0;
      put(s);
      chk(32'(ctl_out[0]), 32'h0000_0000);
      strap.ctl_linear <= 2'h0;
      for (i = 0; i < 7; i++) begin
         if (i != 5) begin
            s = '0;
            if (i < 4) s.alarm[i] = 1'b1;
            else if (i == 4) s.heater_burnout_alarm = 1'b1;
            else s.input_error = 1'b1;
            bus(1'b1, 3'h6, 32'h0000_0001 << i);
            put(s);
            chk(32'(combined_alarm), 32'h0000_0001);
            bus(1'b1, 3'h6, 32'h0000_007F ^ (32'h0000_0001 << i));
            wt(2);
            chk(32'(combined_alarm), 32'h0000_0000);
         end
      end
      put('0);
      bus(1'b1, 3'h0, 32'h0000_0019);
      bus(1'b1, 3'h6, 32'h0000_0020);
      short_current <= 10'h096;
      wt(2);
      chk(32'(combined_alarm), 32'h0000_0001);
      short_current <= 10'h000;
      wt(3);
      chk(32'(heater_short_alarm), 32'h0000_0001);
      pulse(7'h02);
      chk(32'(heater_short_alarm), 32'h0000_0001);
      pulse(7'h01);
      chk(32'(heater_short_alarm), 32'h0000_0000);
      arm();
      pulse(7'h40);
      chk(32'(heater_short_alarm), 32'h0000_0000);
      arm();
      bus(1'b1, 3'h1, 32'h0001_01F4);
      wt(2);
      chk(32'(heater_short_alarm), 32'h0000_0000);
      arm();
      config_level <= 1'b1;
      wt(2);
      chk(32'(heater_short_alarm), 32'h0000_0000);
      config_level <= 1'b0;
      wt(2);
      chk(32'(heater_short_alarm), 32'h0000_0000);
      loop_try(32'h000C_0000, 32'h0000_0004, 1'b1);
      loop_try(32'h000C_0000, 32'h0000_0000, 1'b0);
      loop_try(32'h0002_0000, 32'h0000_0004, 1'b0);
      strap.standard_model <= 1'b0;
      loop_try(32'h000C_0000, 32'h0000_0004, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
